// ### hw/mlc_config_bank.sv
// Loop configuration register bank with AXI4-Lite slave and decoded loop settings
//
// Notes on behaviour
// - Brake code maps to percent of top speed
// - Brake engages at or below threshold only
// - Phase resistance code in bits 15-8
// - Phase inductance code in bits 7-0
// - Back-EMF constant code in bits 30-23
// - Current proportional gain field bits 22-13
// - Current integral gain field bits 12-3
// - Zero current gain selects automatic calculation
// - Speed gain top three bits from 2-0
// - Speed gain: 0.01 x mantissa / 10^exp
// - Current gain register at 8Ch, zero reset
// - Speed gain register at 8Eh, zero reset
// - Speed gain low seven bits 30-24
// - Speed integral gain field bits 23-14
// - Top speed limit bits 13-0
`timescale 1ns/100ps
`include "mlc_defines.svh"

module mlc_config_bank #(
   parameter int ADDR_WIDTH = 12
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_WIDTH-1:0]  s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ADDR_WIDTH-1:0]  s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Loop side
   input  wire logic                   loop_tick,
   input  wire logic                   brake_pin,
   input  wire logic                   stop_brake_request,
   input  wire logic [13:0]            electrical_speed,
   output logic                        brake_engage,
   output logic [9:0]                  brake_speed_limit_pct_x10,
   output logic [7:0]                  phase_resistance_code,
   output logic [7:0]                  phase_inductance_code,
   output logic [7:0]                  back_emf_constant_code,
   output logic [9:0]                  current_prop_gain,
   output logic [9:0]                  current_int_gain,
   output logic                        current_gain_auto,
   output logic [9:0]                  velocity_prop_gain,
   output logic [9:0]                  velocity_int_gain,
   output logic [13:0]                 top_speed_limit
);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Brake threshold in tenths of a percent of the top speed limit
   function automatic logic [9:0] brake_pct_x10(input logic [3:0] code);
      case (code)
         4'h0:    brake_pct_x10 = 10'h3E8;
         4'h1:    brake_pct_x10 = 10'h384;
         4'h2:    brake_pct_x10 = 10'h320;
         4'h3:    brake_pct_x10 = 10'h2BC;
         4'h4:    brake_pct_x10 = 10'h258;
         4'h5:    brake_pct_x10 = 10'h1F4;
         4'h6:    brake_pct_x10 = 10'h1C2;
         4'h7:    brake_pct_x10 = 10'h190;
         4'h8:    brake_pct_x10 = 10'h15E;
         4'h9:    brake_pct_x10 = 10'h12C;
         4'hA:    brake_pct_x10 = 10'h0FA;
         4'hB:    brake_pct_x10 = 10'h0C8;
         4'hC:    brake_pct_x10 = 10'h096;
         4'hD:    brake_pct_x10 = 10'h064;
         4'hE:    brake_pct_x10 = 10'h032;
         default: brake_pct_x10 = 10'h019;
      endcase
   endfunction

   // Maps a byte address to a store slot; slot 3 means unmapped
   function automatic logic [1:0] decode_slot(input logic [ADDR_WIDTH-1:0] addr);
      logic [9:0] idx;
      idx = 10'(addr >> 2);
      if (addr[1:0] != 2'h0) begin
         decode_slot = 2'h3;
      end else if (idx == `MLC_IDX_BRAKE_PARAMS) begin
         decode_slot = `MLC_SLOT_BRAKE_PARAMS;
      end else if (idx == `MLC_IDX_CURRENT_GAIN) begin
         decode_slot = `MLC_SLOT_CURRENT_GAIN;
      end else if (idx == `MLC_IDX_SPEED_GAIN) begin
         decode_slot = `MLC_SLOT_SPEED_GAIN;
      end else begin
         decode_slot = 2'h3;
      end
   endfunction

   // High when a gain field asks for automatic calculation
   function automatic logic gain_is_auto(input logic [9:0] field);
      gain_is_auto = (field == 10'h000);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  aw_held;
      logic                  w_held;
      logic [1:0]            wr_slot;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      mlc_pkg::mlc_rd_state_t rd_state;
      logic [1:0]            rd_slot;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic                  brake_engage;
      logic [9:0]            brake_pct;
      logic [7:0]            res_code;
      logic [7:0]            ind_code;
      logic [7:0]            bemf_code;
      logic [9:0]            ckp;
      logic [9:0]            cki;
      logic                  c_auto;
      logic [9:0]            vkp;
      logic [9:0]            vki;
      logic [13:0]           max_speed;
   } mlc_state_t;

   mlc_state_t              state;
   mlc_state_t              next_state;
   logic                    wr_en;
   logic [31:0]             rf_rd_data;
   logic [2:0][31:0]        words;
   logic [31:0]             w_brake;
   logic [31:0]             w_cur;
   logic [31:0]             w_spd;
   logic [23:0]             speed_scaled;
   logic [23:0]             limit_scaled;
   logic                    speed_below_limit;

   assign wr_en   = state.aw_held && state.w_held && !state.bvalid && state.wr_slot != 2'h3;
   assign w_brake = words[`MLC_SLOT_BRAKE_PARAMS];
   assign w_cur   = words[`MLC_SLOT_CURRENT_GAIN];
   assign w_spd   = words[`MLC_SLOT_SPEED_GAIN];

   ////////////////////////////////////////////////////////////////////////////////
   // Register store

   // Read port takes the slot being accepted, so its data stand in the fetch cycle
   mlc_regfile #(
      .DEPTH (3),
      .WIDTH (32)
   ) u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (wr_en),
      .wr_slot (state.wr_slot),
      .wr_data (state.wdata),
      .wr_strb (state.wstrb),
      .rd_slot (next_state.rd_slot),
      .rd_data (rf_rd_data),
      .words   (words)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_state = state;
      // Write address and data are taken independently, in either order
      if (s_axi_awvalid && state.awready) begin
         next_state.aw_held = 1'b1;
         next_state.wr_slot = decode_slot(s_axi_awaddr);
      end
      if (s_axi_wvalid && state.wready) begin
         next_state.w_held = 1'b1;
         next_state.wdata  = s_axi_wdata;
         next_state.wstrb  = s_axi_wstrb;
      end
      // Both halves held: a mapped slot is written and the response raised together
      if (state.aw_held && state.w_held && !state.bvalid) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = (state.wr_slot == 2'h3) ? `MLC_RESP_SLVERR : `MLC_RESP_OKAY;
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      next_state.awready = !next_state.aw_held && !next_state.bvalid;
      next_state.wready  = !next_state.w_held && !next_state.bvalid;

      // Read: take address, wait for store read, answer
      next_state.arready = 1'b0;
      case (state.rd_state)
         mlc_pkg::MLC_RD_IDLE: begin
            next_state.arready = 1'b1;
            if (s_axi_arvalid && state.arready) begin
               next_state.rd_slot  = decode_slot(s_axi_araddr);
               next_state.arready  = 1'b0;
               next_state.rd_state = mlc_pkg::MLC_RD_FETCH;
            end
         end
         mlc_pkg::MLC_RD_FETCH: begin
            // Store data were registered at the edge that took the address
            next_state.rvalid   = 1'b1;
            next_state.rdata    = (state.rd_slot == 2'h3) ? 32'h00000000 : rf_rd_data;
            next_state.rresp    = (state.rd_slot == 2'h3) ? `MLC_RESP_SLVERR : `MLC_RESP_OKAY;
            next_state.rd_state = mlc_pkg::MLC_RD_RESP;
         end
         mlc_pkg::MLC_RD_RESP: begin
            if (s_axi_rready) begin
               next_state.rvalid   = 1'b0;
               next_state.arready  = 1'b1;
               next_state.rd_state = mlc_pkg::MLC_RD_IDLE;
            end
         end
         default: begin
            next_state.rvalid   = 1'b0;
            next_state.rd_state = mlc_pkg::MLC_RD_IDLE;
         end
      endcase

      // New settings reach the loop only at its evaluation tick
      if (loop_tick) begin
         next_state.brake_pct = brake_pct_x10(
            w_brake[`MLC_BRAKE_CODE_MSB:`MLC_BRAKE_CODE_LSB]);
         next_state.res_code  = w_brake[`MLC_RES_MSB:`MLC_RES_LSB];
         next_state.ind_code  = w_brake[`MLC_IND_MSB:`MLC_IND_LSB];
         next_state.bemf_code = w_cur[`MLC_BEMF_MSB:`MLC_BEMF_LSB];
         next_state.ckp       = w_cur[`MLC_CKP_MSB:`MLC_CKP_LSB];
         next_state.cki       = w_cur[`MLC_CKI_MSB:`MLC_CKI_LSB];
         next_state.c_auto    = gain_is_auto(w_cur[`MLC_CKP_MSB:`MLC_CKP_LSB])
                             || gain_is_auto(w_cur[`MLC_CKI_MSB:`MLC_CKI_LSB]);
         next_state.vkp       = {w_cur[`MLC_VKP_HI_MSB:`MLC_VKP_HI_LSB],
                                 w_spd[`MLC_VKP_LO_MSB:`MLC_VKP_LO_LSB]};
         next_state.vki       = w_spd[`MLC_VKI_MSB:`MLC_VKI_LSB];
         next_state.max_speed = w_spd[`MLC_MAX_SPEED_MSB:`MLC_MAX_SPEED_LSB];
      end

      // Braking from pin or braking stop mode only once speed is down to the threshold
      next_state.brake_engage = (brake_pin || stop_brake_request)
                             && speed_below_limit;
   end

   assign speed_scaled = 24'(electrical_speed) * `MLC_PCT_SCALE;
   assign limit_scaled = 24'(state.max_speed) * 24'(state.brake_pct);
   assign speed_below_limit = (speed_scaled <= limit_scaled);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state          <= '0;
         state.awready  <= 1'b1;
         state.wready   <= 1'b1;
         state.arready  <= 1'b1;
         state.rd_state <= mlc_pkg::MLC_RD_IDLE;
         // Code 0 of the zeroed register decodes to the full top speed
         state.brake_pct <= `MLC_BRAKE_PCT_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready             = state.awready;
   assign s_axi_wready              = state.wready;
   assign s_axi_bresp               = state.bresp;
   assign s_axi_bvalid              = state.bvalid;
   assign s_axi_arready             = state.arready;
   assign s_axi_rdata               = state.rdata;
   assign s_axi_rresp               = state.rresp;
   assign s_axi_rvalid              = state.rvalid;
   assign brake_engage              = state.brake_engage;
   assign brake_speed_limit_pct_x10 = state.brake_pct;
   assign phase_resistance_code     = state.res_code;
   assign phase_inductance_code     = state.ind_code;
   assign back_emf_constant_code    = state.bemf_code;
   assign current_prop_gain         = state.ckp;
   assign current_int_gain          = state.cki;
   assign current_gain_auto         = state.c_auto;
   assign velocity_prop_gain        = state.vkp;
   assign velocity_int_gain         = state.vki;
   assign top_speed_limit           = state.max_speed;

endmodule

// ### hw/mlc_defines.svh
// Register indices, field positions and reset values of the loop configuration bank
`ifndef MLC_DEFINES_SVH
`define MLC_DEFINES_SVH

`define MLC_IDX_BRAKE_PARAMS   10'h08A
`define MLC_IDX_CURRENT_GAIN   10'h08C
`define MLC_IDX_SPEED_GAIN     10'h08E

`define MLC_SLOT_BRAKE_PARAMS  2'h0
`define MLC_SLOT_CURRENT_GAIN  2'h1
`define MLC_SLOT_SPEED_GAIN    2'h2

`define MLC_REG_RESET          32'h00000000
`define MLC_BRAKE_PCT_RESET    10'h3E8

`define MLC_PARITY_BIT         31
`define MLC_BRAKE_CODE_MSB     19
`define MLC_BRAKE_CODE_LSB     16
`define MLC_RES_MSB            15
`define MLC_RES_LSB            8
`define MLC_IND_MSB            7
`define MLC_IND_LSB            0
`define MLC_BEMF_MSB           30
`define MLC_BEMF_LSB           23
`define MLC_CKP_MSB            22
`define MLC_CKP_LSB            13
`define MLC_CKI_MSB            12
`define MLC_CKI_LSB            3
`define MLC_VKP_HI_MSB         2
`define MLC_VKP_HI_LSB         0
`define MLC_VKP_LO_MSB         30
`define MLC_VKP_LO_LSB         24
`define MLC_VKI_MSB            23
`define MLC_VKI_LSB            14
`define MLC_MAX_SPEED_MSB      13
`define MLC_MAX_SPEED_LSB      0

`define MLC_PCT_SCALE          24'h0003E8
`define MLC_RESP_OKAY          2'h0
`define MLC_RESP_SLVERR        2'h2

`endif

// ### hw/mlc_pkg.sv
// Types shared by the loop configuration bank
package mlc_pkg;

   typedef enum logic [1:0] {
      MLC_RD_IDLE  = 2'b00,
      MLC_RD_FETCH = 2'b01,
      MLC_RD_RESP  = 2'b10
   } mlc_rd_state_t;

endpackage

// ### hw/mlc_regfile.sv
// Three-word register store with byte strobes and a registered read port
`timescale 1ns/100ps
`include "mlc_defines.svh"

module mlc_regfile #(
   parameter int DEPTH = 3,
   parameter int WIDTH = 32
) (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         wr_en,
   input  wire logic [1:0]                   wr_slot,
   input  wire logic [WIDTH-1:0]             wr_data,
   input  wire logic [WIDTH/8-1:0]           wr_strb,
   input  wire logic [1:0]                   rd_slot,
   output logic      [WIDTH-1:0]             rd_data,
   output logic      [DEPTH-1:0][WIDTH-1:0]  words
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd_data;
   } mlc_rf_state_t;

   mlc_rf_state_t state;
   mlc_rf_state_t next_state;

   always_comb begin
      next_state = state;
      // Byte-lane merge; every bit, parity included, reads back as written
      if (wr_en && (32'(wr_slot) < DEPTH)) begin
         for (int b = 0; b < WIDTH / 8; b++) begin
            if (wr_strb[b]) begin
               next_state.mem[wr_slot][b*8 +: 8] = wr_data[b*8 +: 8];
            end
         end
      end
      next_state.rd_data = (32'(rd_slot) < DEPTH) ? state.mem[rd_slot] : '0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state.mem     <= {DEPTH{`MLC_REG_RESET}};
         state.rd_data <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rd_data = state.rd_data;
   assign words   = state.mem;

endmodule

// ### test/mlc_config_bank_sva.sv
// Port-level assertion checker for the loop configuration bank
`timescale 1ns/100ps
module mlc_config_bank_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        loop_tick,
   input wire logic        brake_pin,
   input wire logic        stop_brake_request,
   input wire logic [13:0] electrical_speed,
   input wire logic        brake_engage,
   input wire logic [9:0]  brake_speed_limit_pct_x10,
   input wire logic [9:0]  current_prop_gain,
   input wire logic [9:0]  current_int_gain,
   input wire logic        current_gain_auto,
   input wire logic [9:0]  velocity_prop_gain,
   input wire logic [13:0] top_speed_limit
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write channel not freed");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read channel not freed");
   property p_hold;
      !loop_tick |=> $stable(top_speed_limit) && $stable(velocity_prop_gain)
         && $stable(current_prop_gain) && $stable(brake_speed_limit_pct_x10);
   endproperty
   a_hold: assert property (p_hold) else $error("setting changed without tick");
   property p_auto;
      loop_tick |=> current_gain_auto == (current_prop_gain == 10'h000
         || current_int_gain == 10'h000);
   endproperty
   a_auto: assert property (p_auto) else $error("automatic gain flag wrong");
   property p_brake;
      1'b1 |=> brake_engage == $past((brake_pin || stop_brake_request)
         && {18'h00000, electrical_speed} * 32'h000003E8
         <= {18'h00000, top_speed_limit} * {22'h000000, brake_speed_limit_pct_x10});
   endproperty
   a_brake: assert property (p_brake) else $error("brake engage wrong");
   property p_rst_vals;
      $rose(aresetn) |-> brake_speed_limit_pct_x10 == 10'h3E8
         && top_speed_limit == 14'h0000 && velocity_prop_gain == 10'h000;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
   property p_pct_legal;
      loop_tick |=> brake_speed_limit_pct_x10 inside {10'h3E8, 10'h384, 10'h320, 10'h2BC,
         10'h258, 10'h1F4, 10'h1C2, 10'h190, 10'h15E, 10'h12C, 10'h0FA, 10'h0C8,
         10'h096, 10'h064, 10'h032, 10'h019};
   endproperty
   a_pct_legal: assert property (p_pct_legal) else $error("threshold not in table");
   c_brake: cover property (brake_pin && $rose(brake_engage));
   c_auto: cover property (loop_tick ##1 current_gain_auto);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind mlc_config_bank mlc_config_bank_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .loop_tick, .brake_pin, .stop_brake_request,
   .electrical_speed, .brake_engage, .brake_speed_limit_pct_x10, .current_prop_gain,
   .current_int_gain, .current_gain_auto, .velocity_prop_gain, .top_speed_limit);

// ### test/mlc_config_bank_test.sv
// Self-checking bench for the loop configuration bank
`timescale 1ns/100ps
module mlc_config_bank_test;
   logic aclk = 1'b0, aresetn = 1'b0, loop_tick = 1'b0, brake_pin = 1'b0;
   logic stop_brake_request = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000, r2, r3, r4, e2, e3, e4, q;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [13:0] electrical_speed = 14'h0000, sp;
   logic [9:0]  brake_speed_limit_pct_x10, current_prop_gain, current_int_gain;
   logic [9:0]  velocity_prop_gain, velocity_int_gain;
   logic [7:0]  phase_resistance_code, phase_inductance_code, back_emf_constant_code;
   logic [13:0] top_speed_limit;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        brake_engage, current_gain_auto, tk;
   int          errors = 0, cmp_count = 0;

   mlc_config_bank i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loop_tick, .brake_pin,
      .stop_brake_request, .electrical_speed, .brake_engage, .brake_speed_limit_pct_x10,
      .phase_resistance_code, .phase_inductance_code, .back_emf_constant_code,
      .current_prop_gain, .current_int_gain, .current_gain_auto, .velocity_prop_gain,
      .velocity_int_gain, .top_speed_limit);

   initial forever #4 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] pct(input logic [3:0] c);
      return (c < 4'h6) ? 10'h3E8 - 10'h064 * c : (c == 4'hF) ? 10'h019
         : 10'h1F4 - 10'h032 * (c - 4'h5);
   endfunction

   function automatic logic brk(input logic p, input logic [13:0] v, m, input logic [9:0] t);
      return p && ({18'h00000, v} * 32'h000003E8 <= {18'h00000, m} * {22'h000000, t});
   endfunction

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask

   task automatic tick;
      @(posedge aclk) loop_tick <= 1'b1;
      @(posedge aclk) loop_tick <= 1'b0;
      @(posedge aclk);
      {tk, e2, e3, e4} = {1'b1, r2, r3, r4};
   endtask

   task automatic chk_out;
      chk("res", e2[15:8], phase_resistance_code);
      chk("ind", e2[7:0], phase_inductance_code);
      chk("bemf", e3[30:23], back_emf_constant_code);
      chk("ckp", e3[22:13], current_prop_gain);
      chk("cki", e3[12:3], current_int_gain);
      chk("auto", tk && (e3[22:13] == 10'h000 || e3[12:3] == 10'h000), current_gain_auto);
      chk("vkp", {e3[2:0], e4[30:24]}, velocity_prop_gain);
      chk("vki", e4[23:14], velocity_int_gain);
      chk("top", e4[13:0], top_speed_limit);
      chk("pct", pct(e2[19:16]), brake_speed_limit_pct_x10);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      finish_test();
   end

   initial begin
      q = $urandom(32'h29462473);
      {tk, r2, r3, r4, e2, e3, e4} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rc(12'h228, 32'h00000000, 2'h0);
      rc(12'h230, 32'h00000000, 2'h0);
      rc(12'h238, 32'h00000000, 2'h0);
      chk_out;
      $display("Test reset values done");
      wr(12'h22C, 32'hFFFFFFFF, 4'hF, 2'h2);
      wr(12'h231, 32'hFFFFFFFF, 4'hF, 2'h2);
      rc(12'h234, 32'h00000000, 2'h2);
      rc(12'h230, 32'h00000000, 2'h0);
      $display("Test unmapped access done");
      for (int i = 0; i < 12; i++) begin
         r2 = $urandom & 32'h800FFFFF;
         r3 = $urandom;
         r4 = $urandom;
         if (i == 1) r3[22:13] = 10'h000;
         if (i == 2) r3[12:3] = 10'h000;
         if (i == 3) {r3, r4} = {32'hFFFFFFFF, 32'hFFFFFFFF};
         wr(12'h228, r2, 4'hF, 2'h0);
         wr(12'h230, r3, 4'hF, 2'h0);
         wr(12'h238, r4, 4'hF, 2'h0);
         chk_out;
         rc(12'h228, r2, 2'h0);
         rc(12'h230, r3, 2'h0);
         rc(12'h238, r4, 2'h0);
         tick;
         chk_out;
      end
      r4 = r4 & 32'hFF0000FF;
      wr(12'h238, 32'h00000000, 4'h6, 2'h0);
      rc(12'h238, r4, 2'h0);
      r4[13:0] = r4[13:0] | 14'h2A00;
      wr(12'h238, r4, 4'hF, 2'h0);
      rc(12'h238, r4, 2'h0);
      $display("Test random loop settings done");
      for (int c = 0; c < 16; c++) begin
         r2[19:16] = c[3:0];
         wr(12'h228, r2, 4'h4, 2'h0);
         tick;
         chk_out;
         for (int k = 0; k < 2; k++) begin
            q = ({18'h00000, r4[13:0]} * {22'h000000, pct(c[3:0])}) / 32'h000003E8;
            sp = q[13:0] + k[13:0];
            @(posedge aclk);
            brake_pin <= c[0];
            stop_brake_request <= c[1];
            electrical_speed <= sp;
            @(posedge aclk);
            @(posedge aclk);
            chk("brake", brk(c[0] | c[1], sp, r4[13:0], pct(c[3:0])), brake_engage);
         end
      end
      $display("Test brake threshold done");
      finish_test();
   end
endmodule
